//--- hw/chan_pkg.sv
// Package with register map, field layout and result codes of the host channel block.
package chan_pkg;
	localparam logic [8:0] OFS_HUB = 9'h1B8;
	localparam logic [8:0] OFS_FUNC = 9'h1B9;
	localparam logic [8:0] OFS_IVL_HIGH = 9'h1BA;
	localparam logic [8:0] OFS_IVL_LOW = 9'h1BB;
	localparam logic [8:0] OFS_RESULT = 9'h1BE;
	localparam logic [8:0] OFS_TYPE = 9'h1C8;
	localparam logic [7:0] RST_REG = 8'h00;
	localparam int HUB_ADDR_LSB = 4;
	localparam int HUB_PORT_LSB = 0;
	localparam int FUNC_ADDR_LSB = 4;
	localparam int ENDPOINT_LSB = 0;
	localparam int RESULT_LSB = 4;
	localparam int UFRAME_BITS = 3;
	localparam int UFRAME_NS = 125000;
	localparam int CLK_NS = 10;
	localparam int UFRAME_CYC = UFRAME_NS / CLK_NS;
	localparam logic [1:0] TYPE_INTERRUPT = 2'h3;
	typedef enum logic [2:0] {
		RESULT_OK = 3'h0,
		RESULT_STALL = 3'h1,
		RESULT_OVERRUN = 3'h2,
		RESULT_UNDERRUN = 3'h3,
		RESULT_RETRY_FAIL = 3'h4
	} result_code_e;
	typedef struct packed {
		logic done;
		logic stall;
		logic too_long;
		logic beyond_total;
		logic short_pkt;
		logic crc_or_stuff;
		logic toggle_bad;
		logic retry_other;
	} xfer_status_s;
	typedef struct packed {
		logic [3:0] func_addr;
		logic [3:0] endpoint;
	} token_target_s;
endpackage : chan_pkg

//--- hw/host_channel_three.sv
// Host channel target, polling interval and transfer result logic.
`timescale 1ns/1ps
// Overview of operation
// - Hub register bits 7-4 hold a 4-bit hub address, any value 0-15.
// - Hub register bits 2-0 hold hub port 0-7; bit 3 reserved.
// - Function register bits 7-4 hold the token function address 0-15.
// - Function register bits 3-0 hold the token endpoint number 0-15.
// - Interval low three bits count microframes; if they are zero, higher bits count 1 ms frames.
// - Interval applies only when transfer type is interrupt, encoding 11.
// - A zero interval schedules no periodic tokens.
// - A retried transaction waits the same interval before reissue.
// - Read-only 3-bit result code at bits 6-4, bit 7 reserved.
// - Result 000 when the transaction ends with no error.
// - Result 001 when the endpoint answers STALL.
// - Result 010 when a packet exceeds max size or total bytes are exceeded.
// - CRC or stuffing error with overrun or underrun reports retry error.
// - Toggle mismatch on a packet within max size is not an overrun.
// - Result 011 on a short packet with data below the requested total.
// - Result 100 for timeouts, CRC, PID, split errors and toggle mismatch.
// - Transfer type 11 selects interrupt transfer, the only interval user.
module host_channel_three (
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Register port.
	input wire logic [8:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// Transaction engine.
	input wire logic chan_run_in,
	input wire chan_pkg::xfer_status_s status_in,
	output logic token_req_out,
	output chan_pkg::token_target_s token_target_out,
	output logic [3:0] hub_addr_out,
	output logic [2:0] hub_port_out
);
	import chan_pkg::*;

	logic [3:0] hub_addr;
	logic [2:0] hub_port;
	logic [3:0] target_func_addr;
	logic [3:0] target_endpoint;
	logic [10:0] interval;
	logic [1:0] transfer_type;
	logic [2:0] result_code;
	logic [2:0] next_result;
	logic [16:0] uframe_cnt;
	logic uframe_tick;
	logic [10:0] tick_cnt;
	logic [10:0] period;
	logic poll_on;
	logic wait_retry;

	// Register writes.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			hub_addr <= RST_REG[3:0];
			hub_port <= RST_REG[2:0];
			target_func_addr <= RST_REG[3:0];
			target_endpoint <= RST_REG[3:0];
			interval <= {RST_REG[2:0], RST_REG};
			transfer_type <= RST_REG[1:0];
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				OFS_HUB: begin
					hub_addr <= reg_wdata_in[HUB_ADDR_LSB +: 4];
					hub_port <= reg_wdata_in[HUB_PORT_LSB +: 3];
				end
				OFS_FUNC: begin
					target_func_addr <= reg_wdata_in[FUNC_ADDR_LSB +: 4];
					target_endpoint <= reg_wdata_in[ENDPOINT_LSB +: 4];
				end
				OFS_IVL_HIGH: interval[10:8] <= reg_wdata_in[2:0];
				OFS_IVL_LOW: interval[7:0] <= reg_wdata_in;
				OFS_TYPE: transfer_type <= reg_wdata_in[1:0];
				default: ;
			endcase
		end
	end

	// Register reads, data valid in the following cycle.
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			reg_rdata_out <= RST_REG;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				OFS_HUB: reg_rdata_out <= {hub_addr, 1'b0, hub_port};
				OFS_FUNC: reg_rdata_out <= {target_func_addr, target_endpoint};
				OFS_IVL_HIGH: reg_rdata_out <= {5'h00, interval[10:8]};
				OFS_IVL_LOW: reg_rdata_out <= interval[7:0];
				OFS_RESULT: reg_rdata_out <= {1'b0, result_code, 4'h0};
				OFS_TYPE: reg_rdata_out <= {6'h00, transfer_type};
				default: reg_rdata_out <= 8'h00;
			endcase
		end else begin
			reg_rdata_out <= 8'h00;
		end
	end

	// Result classification with precedence.
	always_comb begin
		next_result = RESULT_OK;
		if (status_in.stall) begin
			next_result = RESULT_STALL;
		end else if (status_in.retry_other || status_in.toggle_bad) begin
			next_result = RESULT_RETRY_FAIL;
		end else if ((status_in.too_long || status_in.beyond_total ||
			status_in.short_pkt) && status_in.crc_or_stuff) begin
			next_result = RESULT_RETRY_FAIL;
		end else if (status_in.crc_or_stuff) begin
			next_result = RESULT_RETRY_FAIL;
		end else if (status_in.too_long || status_in.beyond_total) begin
			next_result = RESULT_OVERRUN;
		end else if (status_in.short_pkt) begin
			next_result = RESULT_UNDERRUN;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			result_code <= RESULT_OK;
		end else if (status_in.done) begin
			result_code <= next_result;
		end
	end

	// Interval timing: microframe tick, period in microframes.
	assign period = (interval[2:0] != 3'h0) ? {8'h00, interval[2:0]} :
		{interval[10:3], 3'h0};
	assign poll_on = chan_run_in && (transfer_type == TYPE_INTERRUPT) &&
		(interval != 11'h000);

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			uframe_cnt <= 17'h00000;
			uframe_tick <= 1'b0;
		end else if (uframe_cnt == 17'(UFRAME_CYC - 1)) begin
			uframe_cnt <= 17'h00000;
			uframe_tick <= 1'b1;
		end else begin
			uframe_cnt <= uframe_cnt + 17'h00001;
			uframe_tick <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tick_cnt <= 11'h000;
			token_req_out <= 1'b0;
			wait_retry <= 1'b0;
		end else if (!poll_on) begin
			tick_cnt <= 11'h000;
			token_req_out <= 1'b0;
			wait_retry <= 1'b0;
		end else begin
			token_req_out <= 1'b0;
			if (status_in.done && next_result == RESULT_RETRY_FAIL) begin
				wait_retry <= 1'b1;
				tick_cnt <= 11'h000;
			end else if (uframe_tick) begin
				if (tick_cnt + 11'h001 >= period) begin
					tick_cnt <= 11'h000;
					token_req_out <= 1'b1;
					wait_retry <= 1'b0;
				end else begin
					tick_cnt <= tick_cnt + 11'h001;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			token_target_out <= '0;
			hub_addr_out <= 4'h0;
			hub_port_out <= 3'h0;
		end else begin
			token_target_out <= '{func_addr: target_func_addr, endpoint: target_endpoint};
			hub_addr_out <= hub_addr;
			hub_port_out <= hub_port;
		end
	end

	AST_NO_ZERO_POLL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(interval == 11'h000) |=> !token_req_out) else $error("Token with zero interval.");
	AST_TYPE_GATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(transfer_type != TYPE_INTERRUPT) |=> !token_req_out) else $error("Token on non-interrupt.");
	AST_STALL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(status_in.done && status_in.stall) |=> result_code == RESULT_STALL) else $error("Stall code.");
	AST_CRC_OVR: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(status_in.done && !status_in.stall && status_in.crc_or_stuff && status_in.too_long)
		|=> result_code == RESULT_RETRY_FAIL) else $error("CRC with overrun not retry.");
	AST_TOGGLE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(status_in.done && !status_in.stall && status_in.toggle_bad)
		|=> result_code != RESULT_OVERRUN) else $error("Toggle mismatch as overrun.");
	AST_OK: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(status_in.done && status_in[6:0] == 7'h00) |=> result_code == RESULT_OK) else $error("Ok code.");
	AST_UNDER: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(status_in.done && status_in[6:0] == 7'h08) |=> result_code == RESULT_UNDERRUN) else $error("Underrun.");
	AST_OVER: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(status_in.done && status_in[6:0] == 7'h20) |=> result_code == RESULT_OVERRUN) else $error("Overrun.");
	AST_RD_RESULT: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(reg_rd_in && reg_addr_in == OFS_RESULT) |=> reg_rdata_out[7] == 1'b0
		&& reg_rdata_out[6:4] == $past(result_code)) else $error("Result read.");
	AST_HUB_RD: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
		(reg_rd_in && reg_addr_in == OFS_HUB) |=> reg_rdata_out[3] == 1'b0) else $error("Hub bit 3.");
endmodule : host_channel_three

//--- tb/usb_far_side.sv
// Behavioural model of the bus functions that answer the channel's transactions.
`timescale 1ns/1ps
module usb_far_side
	import chan_pkg::*;
#(parameter int DELAY = 4) (
	// Clock and reset.
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	// Bench control.
	input wire logic go_in,
	input wire logic [6:0] flags_in,
	// Channel side.
	input wire logic token_req_in,
	output chan_pkg::xfer_status_s status_out
);
	int wait_cnt;
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_cnt <= 0;
			status_out <= '0;
		end else begin
			status_out <= '0;
			if (go_in || token_req_in) begin
				wait_cnt <= DELAY;
			end else if (wait_cnt > 0) begin
				wait_cnt <= wait_cnt - 1;
			end
			if (wait_cnt == 1) begin
				status_out <= {1'b1, flags_in};
			end
		end
	end
endmodule : usb_far_side

//--- tb/host_channel_three_tb.sv
// Self-checking bench for the host channel target, interval and result block.
`timescale 1ns/1ps
module host_channel_three_tb;
	import chan_pkg::*;
	logic clk_sys_in;
	logic rst_n_in;
	logic [8:0] reg_addr_in;
	logic [7:0] reg_wdata_in;
	logic reg_wr_in;
	logic reg_rd_in;
	logic [7:0] reg_rdata_out;
	logic chan_run_in;
	xfer_status_s status_in;
	logic token_req_out;
	token_target_s token_target_out;
	logic [3:0] hub_addr_out;
	logic [2:0] hub_port_out;
	logic go;
	logic [6:0] flags;
	int err_count;
	int samples_checked;
	int n;
	logic [7:0] d;
	logic [6:0] f_tab [11] = '{7'h00, 7'h40, 7'h20, 7'h08, 7'h24, 7'h10, 7'h0C, 7'h40, 7'h02, 7'h08, 7'h01};
	logic [2:0] c_tab [11] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h2, 3'h4, 3'h1, 3'h4, 3'h3, 3'h4};
	host_channel_three DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .chan_run_in(chan_run_in),
		.status_in(status_in), .token_req_out(token_req_out),
		.token_target_out(token_target_out), .hub_addr_out(hub_addr_out),
		.hub_port_out(hub_port_out));
	usb_far_side far (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .go_in(go),
		.flags_in(flags), .token_req_in(token_req_out), .status_out(status_in));
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check8
	task automatic check_int(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			err_count++;
			$display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask : check_int
	task automatic wr(input logic [8:0] a, input logic [7:0] v);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= v;
		reg_wr_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
	endtask : wr
	task automatic chk_reg(input logic [8:0] a, input logic [7:0] exp);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
		check8(d, exp);
	endtask : chk_reg
	task automatic wait_tok(input bit must);
		n = 0;
		do begin
			@(posedge clk_sys_in);
			#1;
			n++;
		end while (token_req_out !== 1'b1 && n < 13000);
		if (must && n >= 13000) begin
			err_count++;
			$display("mismatch at %0t: no token", $time);
			stop_test();
		end
	endtask : wait_tok
	initial begin
		rst_n_in = 1'b0;
		reg_addr_in = 9'h000;
		reg_wdata_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		chan_run_in = 1'b0;
		go = 1'b0;
		flags = 7'h00;
		err_count = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		chk_reg(OFS_HUB, RST_REG);
		chk_reg(OFS_FUNC, RST_REG);
		chk_reg(OFS_IVL_HIGH, RST_REG);
		chk_reg(OFS_IVL_LOW, RST_REG);
		chk_reg(OFS_RESULT, RST_REG);
		wr(OFS_HUB, 8'hA5);
		chk_reg(OFS_HUB, 8'hA5);
		check8({hub_addr_out, 1'b0, hub_port_out}, 8'hA5);
		wr(OFS_FUNC, 8'h53);
		chk_reg(OFS_FUNC, 8'h53);
		check8(token_target_out, 8'h53);
		wr(OFS_IVL_HIGH, 8'h05);
		chk_reg(OFS_IVL_HIGH, 8'h05);
		wr(OFS_IVL_LOW, 8'hC8);
		chk_reg(OFS_IVL_LOW, 8'hC8);
		wr(OFS_RESULT, 8'h70);
		chk_reg(OFS_RESULT, 8'h00);
		chk_reg(9'h1BF, 8'h00);
		$display("test registers done");
		chan_run_in <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			@(posedge clk_sys_in);
			go <= 1'b1;
			flags <= f_tab[i];
			@(posedge clk_sys_in);
			go <= 1'b0;
			repeat (8) @(posedge clk_sys_in);
			chk_reg(OFS_RESULT, {1'b0, c_tab[i], 4'h0});
		end
		$display("test results done");
		flags <= 7'h00;
		wr(OFS_IVL_HIGH, 8'h00);
		wr(OFS_IVL_LOW, 8'h01);
		wr(OFS_TYPE, 8'h02);
		wait_tok(1'b0);
		check_int(n, 13000);
		wr(OFS_TYPE, {6'h00, TYPE_INTERRUPT});
		wait_tok(1'b1);
		wait_tok(1'b1);
		check_int(n, UFRAME_CYC);
		chk_reg(OFS_RESULT, 8'h00);
		wr(OFS_IVL_LOW, 8'h00);
		wait_tok(1'b0);
		check_int(n, 13000);
		$display("test interval done");
		stop_test();
	end
endmodule : host_channel_three_tb
